// ==== rtl/gpio_pkg.sv ====
// Constants, register map and carrier types for the pin function block.
// Assumes a 32-bit APB master and full 32-bit byte addresses.
package gpio_pkg;

    localparam int NUM_PORTS     = 4;
    localparam int PINS_PER_PORT = 8;
    localparam int NUM_PINS      = 32;
    localparam int NUM_EXT_IRQ   = 6;

    // Register byte addresses, index is the port number
    localparam logic [3:0][31:0] FSEL_ADDR = {
        32'hffff0d0c, 32'hffff0d08, 32'hffff0d04, 32'hffff0d00};
    localparam logic [3:0][31:0] DATA_ADDR = {
        32'hffff0d50, 32'hffff0d40, 32'hffff0d30, 32'hffff0d20};
    localparam logic [3:0][31:0] SET_ADDR = {
        32'hffff0d54, 32'hffff0d44, 32'hffff0d34, 32'hffff0d24};
    localparam logic [3:0][31:0] CLR_ADDR = {
        32'hffff0d58, 32'hffff0d48, 32'hffff0d38, 32'hffff0d28};
    localparam logic [3:0][31:0] PAR_ADDR = {
        32'hffff0d5c, 32'hffff0d4c, 32'hffff0d3c, 32'hffff0d2c};

    // Reset values
    localparam logic [3:0][31:0] FSEL_RST = {
        32'h11111111, 32'h00000000, 32'h00000000, 32'h00000000};
    localparam logic [3:0][31:0] PAR_RST = {
        32'h00222222, 32'h00000000, 32'h00000000, 32'h20000000};

    // Function register: two selector bits per pin nibble
    localparam logic [31:0] FSEL_MASK  = 32'h33333333;
    localparam int          FSEL_PITCH = 4;
    localparam int          PULL_PITCH = 4;

    // Data register fields
    localparam int DIR_LSB   = 24;
    localparam int DOUT_LSB  = 16;
    localparam int STRAP_LSB = 8;
    localparam int DIN_LSB   = 0;

    // Selector codes
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam logic [1:0] SEL_PLA  = 2'h3;

    // Pin function map, bit 8*port+pin
    localparam logic [31:0] ALT1_AVAIL = 32'h0c3033ff;
    localparam logic [31:0] ALT2_AVAIL = 32'h0000133c;
    localparam logic [31:0] PLA_OUT    = 32'hff30c00c;

    // Pins that carry an external interrupt under selector 00
    localparam logic [5:0][4:0] IRQ_PIN = {
        5'h1b, 5'h1a, 5'h16, 5'h13, 5'h11, 5'h10};

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [3:0][31:0] fsel;
        logic [3:0][31:0] par;
        logic [31:0]      pull_applied;
        logic [31:0]      dir;
        logic [31:0]      dout;
        logic [31:0]      strap;
        logic [31:0]      pin_in;
        logic [31:0]      pad_out;
        logic [31:0]      pad_oe_n;
        logic [31:0]      pull_dis;
        logic [31:0]      prdata;
        logic             pslverr;
    } gpio_state_t;

endpackage

// ==== rtl/gpio_port_function_select.sv ====
// Pin function multiplexer and port registers for four 8-pin ports.
// Assumes an APB master on clk, pads sampled synchronously to clk, and
// peripherals that present per-pin output and enable for codes 01 and 10.
//
// Operation
// - Thirty-two pins in four ports of eight, each port with own registers.
// - After reset pins are plain I/O unless the port reset value differs.
// - Live sampled pin levels always readable in the data register.
// - Pad to logic array input path is always active for every pin.
// - In power-saving mode pins hold level, direction and pull; input routing follows the selector.
// - Function register: pin n selector at bits 4n+1:4n, rest reserved.
// - Code 00 is plain I/O; codes 01 and 10 pick peripheral signals.
// - Code 11 picks logic array; some code 00 pins feed interrupts.
// - A code without mapped function connects no peripheral to the pin.
// - Port 3 selectors reset to 01, ports 0 to 2 reset to 00.
// - Data: direction 31:24, output 23:16, reset strap 15:8, input 7:0.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_function_select (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Register bus
    input  wire gpio_pkg::apb_req_t apb_req,
    output gpio_pkg::apb_rsp_t      apb_rsp,
    // Power mode
    input  wire logic              power_save,
    // Pads
    input  wire logic [31:0]       pad_in,
    output logic [31:0]            pad_out,
    output logic [31:0]            pad_oe_n,
    output logic [31:0]            pull_disable,
    // Peripheral functions, codes 01 and 10
    input  wire logic [31:0]       alt1_out,
    input  wire logic [31:0]       alt1_oe,
    input  wire logic [31:0]       alt2_out,
    input  wire logic [31:0]       alt2_oe,
    output logic [31:0]            alt1_in,
    output logic [31:0]            alt2_in,
    // Logic array and interrupts
    input  wire logic [31:0]       logic_array_output,
    output logic [31:0]            logic_array_input,
    output logic [5:0]             external_interrupt_input
);

    gpio_pkg::gpio_state_t s;
    gpio_pkg::gpio_state_t next_s;

    logic setup;
    logic wr;
    logic [1:0] sel [gpio_pkg::NUM_PINS];
    logic [31:0] mux_drive;
    logic [31:0] mux_val;

    // Gather the pull-up disable bits, one per pin nibble
    function automatic logic [7:0] pull_bits(input logic [31:0] par);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < gpio_pkg::PINS_PER_PORT; k++) begin
            r[k] = par[k * gpio_pkg::PULL_PITCH];
        end
        return r;
    endfunction

    // Reset image of the whole state
    function automatic gpio_pkg::gpio_state_t reset_state();
        gpio_pkg::gpio_state_t r;
        r = '0;
        r.fsel = gpio_pkg::FSEL_RST;
        r.par  = gpio_pkg::PAR_RST;
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            r.pull_applied[p*8 +: 8] = pull_bits(gpio_pkg::PAR_RST[p]);
        end
        r.pull_dis = r.pull_applied;
        r.pad_oe_n = '1;
        return r;
    endfunction

    assign setup = apb_req.psel && !apb_req.penable;
    assign wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;

    // Per-pin selector, pad mux and peripheral inputs
    genvar gi;
    generate
        for (gi = 0; gi < gpio_pkg::NUM_PINS; gi++) begin : g_pin
            localparam int PORT = gi / gpio_pkg::PINS_PER_PORT;
            localparam int POS  = gi % gpio_pkg::PINS_PER_PORT;
            logic drive;
            logic val;
            assign sel[gi] =
                s.fsel[PORT][POS * gpio_pkg::FSEL_PITCH +: 2];
            always_comb begin
                case (sel[gi])
                    gpio_pkg::SEL_GPIO: begin
                        drive = s.dir[gi];
                        val   = s.dout[gi];
                    end
                    gpio_pkg::SEL_ALT1: begin
                        drive = gpio_pkg::ALT1_AVAIL[gi]
                                & alt1_oe[gi];
                        val   = alt1_out[gi];
                    end
                    gpio_pkg::SEL_ALT2: begin
                        drive = gpio_pkg::ALT2_AVAIL[gi]
                                & alt2_oe[gi];
                        val   = alt2_out[gi];
                    end
                    gpio_pkg::SEL_PLA: begin
                        drive = gpio_pkg::PLA_OUT[gi];
                        val   = logic_array_output[gi];
                    end
                    default: begin
                        drive = 1'b0;
                        val   = 1'b0;
                    end
                endcase
            end
            assign mux_drive[gi] = drive;
            assign mux_val[gi]   = val;
            // Peripheral inputs only where the map gives that function
            assign alt1_in[gi] = (sel[gi] == gpio_pkg::SEL_ALT1)
                & gpio_pkg::ALT1_AVAIL[gi] & s.pin_in[gi];
            assign alt2_in[gi] = (sel[gi] == gpio_pkg::SEL_ALT2)
                & gpio_pkg::ALT2_AVAIL[gi] & s.pin_in[gi];
        end
    endgenerate

    // Interrupt pins pass only while in plain I/O mode
    genvar gq;
    generate
        for (gq = 0; gq < gpio_pkg::NUM_EXT_IRQ; gq++) begin : g_irq
            localparam int PIN = gpio_pkg::IRQ_PIN[gq];
            assign external_interrupt_input[gq] =
                (sel[PIN] == gpio_pkg::SEL_GPIO) & s.pin_in[PIN];
        end
    endgenerate

    always_comb begin
        next_s        = s;
        next_s.pin_in = pad_in;

        // Register writes take effect in the access phase
        if (wr) begin
            for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
                if (apb_req.paddr == gpio_pkg::FSEL_ADDR[p]) begin
                    next_s.fsel[p] = apb_req.pwdata & gpio_pkg::FSEL_MASK;
                end
                if (apb_req.paddr == gpio_pkg::PAR_ADDR[p]) begin
                    next_s.par[p] = apb_req.pwdata;
                end
                if (apb_req.paddr == gpio_pkg::DATA_ADDR[p]) begin
                    next_s.dir[p*8 +: 8] =
                        apb_req.pwdata[gpio_pkg::DIR_LSB +: 8];
                    next_s.dout[p*8 +: 8] =
                        apb_req.pwdata[gpio_pkg::DOUT_LSB +: 8];
                    // Parameters only reach the pads here
                    next_s.pull_applied[p*8 +: 8] = pull_bits(s.par[p]);
                end
                if (apb_req.paddr == gpio_pkg::SET_ADDR[p]) begin
                    next_s.dout[p*8 +: 8] = s.dout[p*8 +: 8]
                        | apb_req.pwdata[gpio_pkg::DOUT_LSB +: 8];
                end
                if (apb_req.paddr == gpio_pkg::CLR_ADDR[p]) begin
                    next_s.dout[p*8 +: 8] = s.dout[p*8 +: 8]
                        & ~apb_req.pwdata[gpio_pkg::DOUT_LSB +: 8];
                end
            end
        end

        // Read data captured in the setup cycle, so prdata is a flop
        if (setup) begin
            next_s.prdata  = '0;
            next_s.pslverr = 1'b1;
            for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
                if (apb_req.paddr == gpio_pkg::FSEL_ADDR[p]) begin
                    next_s.prdata  = s.fsel[p] & gpio_pkg::FSEL_MASK;
                    next_s.pslverr = 1'b0;
                end
                if (apb_req.paddr == gpio_pkg::PAR_ADDR[p]) begin
                    next_s.prdata  = s.par[p];
                    next_s.pslverr = 1'b0;
                end
                if (apb_req.paddr == gpio_pkg::DATA_ADDR[p]) begin
                    next_s.prdata[gpio_pkg::DIR_LSB +: 8]   = s.dir[p*8 +: 8];
                    next_s.prdata[gpio_pkg::DOUT_LSB +: 8]  = s.dout[p*8 +: 8];
                    next_s.prdata[gpio_pkg::STRAP_LSB +: 8] = s.strap[p*8 +: 8];
                    // Live level whatever the selector says
                    next_s.prdata[gpio_pkg::DIN_LSB +: 8]   = s.pin_in[p*8 +: 8];
                    next_s.pslverr = 1'b0;
                end
                // Set and clear are write-only, read as zero
                if (apb_req.paddr == gpio_pkg::SET_ADDR[p]
                    || apb_req.paddr == gpio_pkg::CLR_ADDR[p]) begin
                    next_s.pslverr = 1'b0;
                end
            end
        end

        // Pad mux; frozen in power-saving mode so pins keep their state
        if (!power_save) begin
            next_s.pad_oe_n = ~mux_drive;
            next_s.pad_out  = mux_drive & mux_val;
            next_s.pull_dis = s.pull_applied;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= reset_state();
            // Pin levels seen during reset, kept for readback
            s.strap <= pad_in;
        end else begin
            s <= next_s;
        end
    end

    // Ungated so the array sees pins in every mode
    assign logic_array_input = s.pin_in;

    assign pad_out      = s.pad_out;
    assign pad_oe_n     = s.pad_oe_n;
    assign pull_disable = s.pull_dis;

    // Zero wait states: ready throughout the access phase
    assign apb_rsp.pready  = apb_req.psel && apb_req.penable;
    assign apb_rsp.prdata  = s.prdata;
    assign apb_rsp.pslverr = s.pslverr && apb_req.psel && apb_req.penable;

endmodule

`default_nettype wire

// ==== sim/gpio_fsel_assertions.sv ====
// Port-level checker for the pin function block.
// Assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpio_fsel_checker (
    // Clock and reset
    input wire logic               clk,
    input wire logic               srst,
    // Register bus
    input wire gpio_pkg::apb_req_t apb_req,
    input wire gpio_pkg::apb_rsp_t apb_rsp,
    // Pads and functions
    input wire logic               power_save,
    input wire logic [31:0]        pad_in,
    input wire logic [31:0]        pad_out,
    input wire logic [31:0]        pad_oe_n,
    input wire logic [31:0]        pull_disable,
    input wire logic [31:0]        alt1_in,
    input wire logic [31:0]        alt2_in,
    input wire logic [31:0]        logic_array_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence apb_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence apb_access;
        apb_req.psel && apb_req.penable && apb_rsp.pready;
    endsequence
    AST_READY_ZERO_WAIT: assert property (
        apb_rsp.pready == (apb_req.psel && apb_req.penable))
        else $error("pready not zero wait");
    AST_SLVERR_IN_ACCESS: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr outside access");
    AST_READ_HOLDS: assert property (
        apb_setup ##1 apb_access |=> $stable(apb_rsp.prdata))
        else $error("read data moved after access");
    AST_PLA_PATH: assert property (
        !$past(srst) |-> logic_array_input == $past(pad_in))
        else $error("logic array input not pad sample");
    AST_ALT_MAPPED: assert property (
        ((alt1_in & ~gpio_pkg::ALT1_AVAIL) == 32'h0)
        && ((alt2_in & ~gpio_pkg::ALT2_AVAIL) == 32'h0))
        else $error("peripheral input on unmapped pin");
    AST_ALT_FROM_PAD: assert property (
        ((alt1_in | alt2_in) & ~logic_array_input) == 32'h0)
        else $error("peripheral input not from pad");
    AST_FREEZE: assert property (
        $past(power_save) && !$past(srst) |-> $stable(pad_out)
        && $stable(pad_oe_n) && $stable(pull_disable))
        else $error("pads moved in power save");
    AST_RESET_PADS: assert property (
        $past(srst) |-> pad_oe_n == 32'hffffffff && pad_out == 32'h0)
        else $error("pads not released by reset");
    AST_UNDRIVEN_LOW: assert property (
        (pad_out & pad_oe_n) == 32'h0)
        else $error("undriven pad not low");
endmodule
bind gpio_port_function_select gpio_fsel_checker u_chk (.clk(clk),
    .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .power_save(power_save), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pull_disable(pull_disable), .alt1_in(alt1_in),
    .alt2_in(alt2_in), .logic_array_input(logic_array_input));
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the pin function block.
// Assumes the checker is bound separately; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               psv = 1'b0;
    gpio_pkg::apb_req_t req = '0;
    gpio_pkg::apb_rsp_t rsp;
    logic [31:0]        pin = 32'h5a0000c3;
    logic [31:0]        a1o = '0, a1e = '0, a2o = '0, a2e = '0, lao = '0;
    logic [31:0]        pout, poe_n, pud, a1i, a2i, q, lai;
    logic [5:0]         irq;
    logic               err;
    int                 mismatches = 0;
    int                 n_compared = 0;
    // Address, write flag, write data, expected read
    logic [96:0]        rows [13] = '{
        {32'hffff0d00, 65'h0}, {32'hffff0d04, 65'h0},
        {32'hffff0d08, 65'h0}, {32'hffff0d0c, 33'h0, 32'h11111111},
        {32'hffff0d2c, 33'h0, 32'h20000000}, {32'hffff0d3c, 65'h0},
        {32'hffff0d4c, 65'h0}, {32'hffff0d5c, 33'h0, 32'h00222222},
        {32'hffff0d20, 33'h0, 32'h0000c3c3},
        {32'hffff0d50, 33'h0, 32'h00005a5a},
        {32'hffff0d08, 1'b1, 64'hffffffff33333333},
        {32'hffff0d08, 1'b1, 64'h0},
        {32'hffff0d3c, 1'b1, 64'h5a5a5a5a5a5a5a5a}};

    gpio_port_function_select DUT (.clk(clk), .srst(srst), .apb_req(req),
        .apb_rsp(rsp), .power_save(psv), .pad_in(pin), .pad_out(pout),
        .pad_oe_n(poe_n), .pull_disable(pud), .alt1_out(a1o), .alt1_oe(a1e),
        .alt2_out(a2o), .alt2_oe(a2e), .alt1_in(a1i), .alt2_in(a2i),
        .logic_array_output(lao), .logic_array_input(lai),
        .external_interrupt_input(irq));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns one edge after release
    task automatic apb(input logic w, input logic [31:0] a, d);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        for (int n = 0; n < 16 && rsp.pready !== 1'b1; n++) @(posedge clk);
        chk({31'h0, rsp.pready}, 32'h1);
        q = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        finish_test;
    end

    // Port 1 registers touched only in the register table rows
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(poe_n, 32'hffffffff);
        foreach (rows[i]) begin
            if (rows[i][64]) apb(1'b1, rows[i][96:65], rows[i][63:32]);
            apb(1'b0, rows[i][96:65], 32'h0);
            chk(q, rows[i][31:0]);
            chk({31'h0, err}, 32'h0);
        end
        apb(1'b0, 32'hffff0d10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, 32'hffff0d2c, 32'h10000001);
        repeat (2) @(posedge clk);
        chk({24'h0, pud[7:0]}, 32'h0);
        apb(1'b1, 32'hffff0d20, 32'hffa50000);
        repeat (2) @(posedge clk);
        chk({pud[7:0], pout[7:0], poe_n[7:0], 8'h0}, 32'h81a50000);
        a1o <= 32'h96;
        a1e <= 32'hff;
        pin <= 32'h5a00003c;
        apb(1'b1, 32'hffff0d00, 32'h11111111);
        repeat (2) @(posedge clk);
        chk({a1i[7:0], a2i[7:0], pout[7:0], poe_n[7:0]}, 32'h3c009600);
        apb(1'b0, 32'hffff0d20, 32'h0);
        chk(q, 32'hffa5c33c);
        a2o <= 32'hff;
        a2e <= 32'hff;
        apb(1'b1, 32'hffff0d00, 32'h22222222);
        repeat (2) @(posedge clk);
        chk({a1i[7:0], a2i[7:0], 4'h0, pout[5:2], 4'h0, poe_n[5:2]},
            32'h003c0f00);
        lao <= 32'ha6000000;
        pin <= 32'h0c4b003c;
        apb(1'b1, 32'hffff0d0c, 32'h33333333);
        repeat (2) @(posedge clk);
        chk({pout[31:24], poe_n[31:24], 10'h0, irq}, 32'ha600000f);
        apb(1'b1, 32'hffff0d0c, 32'h0);
        repeat (2) @(posedge clk);
        chk({26'h0, irq}, 32'h3f);
        apb(1'b1, 32'hffff0d00, 32'h0);
        psv <= 1'b1;
        apb(1'b1, 32'hffff0d20, 32'h005a0000);
        repeat (2) @(posedge clk);
        chk({16'h0, pout[7:0], poe_n[7:0]}, 32'h0000a500);
        psv <= 1'b0;
        repeat (3) @(posedge clk);
        chk({16'h0, pout[7:0], poe_n[7:0]}, 32'h000000ff);
        chk(lai, 32'h0c4b003c);
        apb(1'b1, 32'hffff0d24, 32'h00810000);
        apb(1'b1, 32'hffff0d28, 32'h00180000);
        apb(1'b0, 32'hffff0d20, 32'h0);
        chk(q, 32'h00c3c33c);
        apb(1'b0, 32'hffff0d24, 32'h0);
        chk({err, q[30:0]}, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
